/* File: rtl/spi_flow_pkg.sv */
// Shared constants and types for the serial register-access target.
// Assumes a single core clock domain; serial pins are synchronised in the target.
package spi_flow_pkg;

   // Header layout, counted within the 32-bit word as shifted in MSB first.
   localparam int HDR_BITS = 32;
   localparam int HDR_DIR_BIT = 31;
   localparam int HDR_LEN_MSB = 29;
   localparam int HDR_LEN_LSB = 24;
   localparam int HDR_ADDR_MSB = 23;

   // Flow-control bytes driven on the serial output, and the number of wait bytes for reads.
   localparam logic [7:0] WAIT_BYTE = 8'h00;
   localparam logic [7:0] ACK_BYTE = 8'h01;
   localparam logic [7:0] UNMAPPED_BYTE = 8'hff;
   localparam logic [7:0] READ_WAIT_BYTES = 8'h01;

   // Register map: base, locality banks and per-bank offsets.
   localparam logic [7:0] BASE_HI = 8'hd4;
   localparam logic [23:0] REG_BASE = 24'hd40000;
   localparam logic [23:0] LOC_STRIDE = 24'h001000;
   localparam logic [3:0] NUM_LOC = 4'h5;
   localparam int BANK_BYTES = 32;
   localparam int STORE_DEPTH = 160;
   localparam logic [4:0] OFF_OWNERSHIP = 5'h00;
   localparam logic [4:0] OFF_INT_CONFIG = 5'h08;
   localparam logic [4:0] OFF_IRQ_VECTOR = 5'h0c;
   localparam logic [4:0] OFF_INT_EVENTS = 5'h10;
   localparam logic [4:0] OFF_CAPABILITY = 5'h14;
   localparam logic [4:0] OFF_STATUS = 5'h18;

   // Field positions inside the ownership and status bytes.
   localparam int OWN_VALID_BIT = 7;
   localparam int STS_VALID_BIT = 7;
   localparam int STS_PENDING_BIT = 4;

   // Host-side retry limit before declaring the device failed.
   localparam int HOST_TIMEOUT_MS = 2000;

   typedef enum logic [5:0] {
      ST_IDLE = 6'b000001,
      ST_HEADER = 6'b000010,
      ST_WAIT = 6'b000100,
      ST_ACK = 6'b001000,
      ST_DATA = 6'b010000,
      ST_DONE = 6'b100000
   } xfer_state_t;

endpackage

/* File: rtl/spi_reg_store.sv */
// Byte store holding the writable bytes of all locality banks.
// Assumes writes and reads come from logic on the same clock; read data is registered.
`timescale 1ns/1ps
`default_nettype none
module spi_reg_store
#(
   parameter int DEPTH = 160,
   parameter int ADDR_W = 8
)
(
   input wire logic core_clk_i,
   input wire logic rstn_i,
   input wire logic we_i,
   input wire logic [ADDR_W-1:0] waddr_i,
   input wire logic [7:0] wdata_i,
   input wire logic [ADDR_W-1:0] raddr_i,
   output logic [7:0] rdata_o
);

   typedef struct packed {
      logic [DEPTH-1:0][7:0] mem;
      logic [7:0] rd;
   } store_t;

   store_t s_q;
   store_t s_d;

   always_comb
   begin
      s_d = s_q;
      if (we_i && (int'(waddr_i) < DEPTH))
      begin
         s_d.mem[waddr_i] = wdata_i;
      end
      s_d.rd = (int'(raddr_i) < DEPTH) ? s_q.mem[raddr_i] : 8'h00;
   end

   always_ff @(posedge core_clk_i)
   begin
      if (!rstn_i)
      begin
         s_q <= '0;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   assign rdata_o = s_q.rd;

endmodule
`default_nettype wire

/* File: rtl/spi_register_access_flow_control.sv */
// Serial target that decodes request headers, inserts flow control and serves the locality banks.
// Assumes mode-0 serial timing and a serial clock well below a quarter of the core clock.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - First header bit: 1 read, 0 write
// - Six-bit length holds byte count minus one
// - Length field sent most significant bit first
// - 24-bit address follows, MSB first
// - Wait states drive the output low
// - Acknowledge byte ends in one; data follows
// - Reads get exactly one wait state
// - Writes get one or more wait states
// - Status bit 7 qualifies pending and expect; no expect bit here, status has only pending
// - Ownership bit 7 qualifies its other bits
// - Decoding starts at a fixed base address
// - Five banks, 0x1000 stride, ownership at zero
// - Interrupt events register at offset 0x10
// - Vector register at 0x0C drives no pin
// - Capability register at offset 0x14
// - Chip select frames; output low at start
// - Command byte, three address bytes, then data
module spi_register_access_flow_control
#(
   parameter logic [7:0] WRITE_WAIT_BYTES = 8'h01,
   parameter logic [31:0] CAPABILITY = 32'h0000_0000
)
(
   input wire logic core_clk_i,
   input wire logic rstn_i,
   input wire logic spi_clk_i,
   input wire logic spi_cs_n_i,
   input wire logic spi_mosi_i,
   output logic spi_miso_o,
   output logic spi_miso_oe_o,
   input wire logic status_fields_valid_i,
   input wire logic read_data_pending_i,
   input wire logic [7:0] irq_event_i,
   output logic xfer_done_o
);
   import spi_flow_pkg::*;

   typedef struct packed {
      logic sclk_s1;
      logic sclk_s2;
      logic sclk_s3;
      logic cs_s1;
      logic cs_s2;
      logic cs_s3;
      logic mosi_s1;
      logic mosi_s2;
      xfer_state_t state;
      logic [4:0] cnt;
      logic [31:0] hdr;
      logic is_read;
      logic [5:0] len;
      logic [23:0] addr;
      logic [5:0] idx;
      logic [7:0] wait_left;
      logic [7:0] rx;
      logic [7:0] tx;
      logic miso;
      logic oe;
      logic wr_en;
      logic [7:0] wr_addr;
      logic [7:0] wr_data;
      logic [7:0] events;
      logic own_valid;
      logic done;
   } target_t;

   target_t r_q;
   target_t r_d;
   logic [7:0] store_rd;
   logic [23:0] cur_addr;
   logic cur_hit;
   logic [7:0] rd_val;
   logic sclk_rise;
   logic sclk_fall;
   logic cs_fall;
   logic [31:0] hdr_full;
   logic [7:0] rx_full;

   // Returns whether an address falls inside a locality bank's implemented window.
   function automatic logic reg_hit(input logic [23:0] a);
      reg_hit = (a[23:16] == BASE_HI) && (a[15:12] < NUM_LOC) && (a[11:5] == 7'h00);
   endfunction

   // Maps an address onto the byte store: locality in the top bits, bank offset below.
   function automatic logic [7:0] reg_index(input logic [23:0] a);
      reg_index = {a[14:12], a[4:0]};
   endfunction

   assign sclk_rise = r_q.sclk_s2 & ~r_q.sclk_s3;
   assign sclk_fall = ~r_q.sclk_s2 & r_q.sclk_s3;
   assign cs_fall = ~r_q.cs_s2 & r_q.cs_s3;
   assign hdr_full = {r_q.hdr[30:0], r_q.mosi_s2};
   assign rx_full = {r_q.rx[6:0], r_q.mosi_s2};
   assign cur_addr = r_q.addr + {18'h00000, r_q.idx};
   assign cur_hit = reg_hit(cur_addr);

   spi_reg_store #(
      .DEPTH(STORE_DEPTH),
      .ADDR_W(8)
   ) u_store (
      .core_clk_i(core_clk_i),
      .rstn_i(rstn_i),
      .we_i(r_q.wr_en),
      .waddr_i(r_q.wr_addr),
      .wdata_i(r_q.wr_data),
      .raddr_i(reg_index(cur_addr)),
      .rdata_o(store_rd)
   );

   // Read value of the byte at the current transfer address.
   always_comb
   begin
      rd_val = 8'h00;
      if (!cur_hit)
      begin
         rd_val = UNMAPPED_BYTE;
      end
      else if (cur_addr[4:0] == OFF_OWNERSHIP)
      begin
         rd_val = store_rd;
         rd_val[OWN_VALID_BIT] = r_q.own_valid;
      end
      else if ((cur_addr[4:0] >= OFF_INT_CONFIG) && (cur_addr[4:0] <= OFF_IRQ_VECTOR))
      begin
         rd_val = store_rd;
      end
      else if (cur_addr[4:0] == OFF_INT_EVENTS)
      begin
         rd_val = r_q.events;
      end
      else if (cur_addr[4:2] == OFF_CAPABILITY[4:2])
      begin
         rd_val = CAPABILITY[{cur_addr[1:0], 3'b000} +: 8];
      end
      else if (cur_addr[4:0] == OFF_STATUS)
      begin
         rd_val[STS_VALID_BIT] = status_fields_valid_i;
         rd_val[STS_PENDING_BIT] = read_data_pending_i;
      end
   end

   always_comb
   begin
      r_d = r_q;
      r_d.sclk_s1 = spi_clk_i;
      r_d.sclk_s2 = r_q.sclk_s1;
      r_d.sclk_s3 = r_q.sclk_s2;
      r_d.cs_s1 = spi_cs_n_i;
      r_d.cs_s2 = r_q.cs_s1;
      r_d.cs_s3 = r_q.cs_s2;
      r_d.mosi_s1 = spi_mosi_i;
      r_d.mosi_s2 = r_q.mosi_s1;
      r_d.wr_en = 1'b0;
      r_d.done = 1'b0;
      r_d.own_valid = 1'b1;
      // Hardware-set event bits win over a clear in the same cycle.
      r_d.events = r_q.events | irq_event_i;
      if (r_q.cs_s2)
      begin
         // Chip select high ends the frame wherever the sequence stands.
         r_d.state = ST_IDLE;
         r_d.oe = 1'b0;
         r_d.miso = 1'b0;
      end
      else if (cs_fall)
      begin
         r_d.state = ST_HEADER;
         r_d.cnt = 5'h00;
         r_d.idx = 6'h00;
         r_d.tx = 8'h00;
         r_d.miso = 1'b0;
         r_d.oe = 1'b1;
      end
      else if (sclk_rise)
      begin
         r_d.cnt = r_q.cnt + 5'h01;
         r_d.hdr = hdr_full;
         r_d.rx = rx_full;
         case (r_q.state)
            ST_HEADER:
            begin
               if (r_q.cnt == 5'(HDR_BITS - 1))
               begin
                  r_d.is_read = hdr_full[HDR_DIR_BIT];
                  r_d.len = hdr_full[HDR_LEN_MSB:HDR_LEN_LSB];
                  r_d.addr = hdr_full[HDR_ADDR_MSB:0];
                  r_d.wait_left = hdr_full[HDR_DIR_BIT] ? READ_WAIT_BYTES : WRITE_WAIT_BYTES;
                  r_d.state = ST_WAIT;
               end
            end
            ST_WAIT:
            begin
               if (r_q.cnt[2:0] == 3'h7)
               begin
                  r_d.wait_left = r_q.wait_left - 8'h01;
                  if (r_q.wait_left <= 8'h01)
                  begin
                     r_d.state = ST_ACK;
                  end
               end
            end
            ST_ACK:
            begin
               if (r_q.cnt[2:0] == 3'h7)
               begin
                  r_d.state = ST_DATA;
               end
            end
            ST_DATA:
            begin
               if (r_q.cnt[2:0] == 3'h7)
               begin
                  if (!r_q.is_read && cur_hit)
                  begin
                     if (cur_addr[4:0] == OFF_INT_EVENTS)
                     begin
                        r_d.events = (r_q.events & ~rx_full) | irq_event_i;
                     end
                     else if ((cur_addr[4:0] == OFF_OWNERSHIP) ||
                              ((cur_addr[4:0] >= OFF_INT_CONFIG) && (cur_addr[4:0] <= OFF_IRQ_VECTOR)))
                     begin
                        r_d.wr_en = 1'b1;
                        r_d.wr_addr = reg_index(cur_addr);
                        r_d.wr_data = rx_full;
                     end
                  end
                  r_d.idx = r_q.idx + 6'h01;
                  if (r_q.idx == r_q.len)
                  begin
                     r_d.state = ST_DONE;
                     r_d.done = 1'b1;
                  end
               end
            end
            ST_DONE:
            begin
               r_d.state = ST_DONE;
            end
            default:
            begin
               r_d.state = ST_IDLE;
            end
         endcase
      end
      else if (sclk_fall && (r_q.state != ST_IDLE))
      begin
         if (r_q.cnt[2:0] == 3'h0)
         begin
            case (r_q.state)
               ST_WAIT: r_d.tx = WAIT_BYTE;
               ST_ACK: r_d.tx = ACK_BYTE;
               ST_DATA: r_d.tx = r_q.is_read ? rd_val : 8'h00;
               default: r_d.tx = 8'h00;
            endcase
         end
         else
         begin
            r_d.tx = {r_q.tx[6:0], 1'b0};
         end
         r_d.miso = r_d.tx[7];
      end
   end

   always_ff @(posedge core_clk_i)
   begin
      if (!rstn_i)
      begin
         r_q <= '0;
         r_q.state <= ST_IDLE;
         r_q.sclk_s1 <= 1'b0;
         r_q.cs_s1 <= 1'b1;
         r_q.cs_s2 <= 1'b1;
         r_q.cs_s3 <= 1'b1;
      end
      else
      begin
         r_q <= r_d;
      end
   end

   assign spi_miso_o = r_q.miso;
   assign spi_miso_oe_o = r_q.oe;
   assign xfer_done_o = r_q.done;

   // The header-complete moment is used by several checks below.
   logic hdr_done;
   assign hdr_done = sclk_rise && !r_q.cs_s2 && (r_q.state == ST_HEADER) && (r_q.cnt == 5'(HDR_BITS - 1));

   chk_frame_start_low: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      cs_fall && !r_q.cs_s2 |=> !spi_miso_o && spi_miso_oe_o && (r_q.state == ST_HEADER))
      else $error("output not low and driven at frame start");

   chk_header_direction: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      hdr_done |=> (r_q.is_read == $past(r_q.hdr[30])))
      else $error("direction not taken from first header bit");

   chk_length_field: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      hdr_done |=> (r_q.len == $past(r_q.hdr[28:23])) && (r_q.idx == 6'h00))
      else $error("length field misplaced");

   chk_address_field: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      hdr_done |=> (r_q.addr == {$past(r_q.hdr[22:0]), $past(r_q.mosi_s2)}))
      else $error("address not assembled MSB first");

   chk_read_one_wait: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      hdr_done && r_q.hdr[30] |=> (r_q.state == ST_WAIT) && (r_q.wait_left == 8'h01))
      else $error("read did not get exactly one wait state");

   chk_wait_drives_low: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      sclk_fall && !r_q.cs_s2 && (r_q.state == ST_WAIT) |=> !spi_miso_o)
      else $error("wait state not low on output");

   chk_ack_last_bit: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      sclk_fall && !r_q.cs_s2 && (r_q.state == ST_ACK) && (r_q.cnt[2:0] == 3'h7) |=> spi_miso_o)
      else $error("acknowledge byte does not end in one");

   chk_data_after_ack: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      (r_q.state != ST_DATA) ##1 (r_q.state == ST_DATA) |-> ($past(r_q.state) == ST_ACK))
      else $error("data phase entered without acknowledge");

   chk_length_end: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      xfer_done_o |-> (r_q.state == ST_DONE) && (r_q.idx == r_q.len + 6'h01))
      else $error("transfer ended at the wrong byte count");

   chk_status_valid: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      cur_hit && (cur_addr[4:0] == OFF_STATUS) |-> (rd_val[STS_VALID_BIT] == status_fields_valid_i))
      else $error("status valid bit not reported");

   chk_write_decode: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      r_q.wr_en |-> ($past(cur_addr[23:16]) == REG_BASE[23:16]) && (r_q.wr_addr[7:5] < 3'h5))
      else $error("store written outside the decoded banks");

endmodule
`default_nettype wire

/* File: verif/spi_host_model.sv */
// Host serial master model, mode 0, one frame per call.
// Assumes the target answers a few core cycles after each falling serial clock.
`timescale 1ns/1ps
`default_nettype none
module spi_host_model
(
   output logic sclk_o,
   output logic cs_n_o,
   output logic mosi_o,
   input wire logic miso_i
);
   logic [7:0] buf_q [64];
   logic [7:0] ack_q;
   int waits_q;
   logic hdr_ok_q;
   logic wait_ok_q;

   initial
   begin
      sclk_o = 1'b0;
      cs_n_o = 1'b1;
      mosi_o = 1'b1;
   end

   task automatic shift(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--)
      begin
         mosi_o = tx[i];
         #62.5 sclk_o = 1'b1;
         rx[i] = miso_i;
         #62.5 sclk_o = 1'b0;
      end
   endtask

   // Host software would retry a read whose data is not ready; this model never retries.
   task automatic frame(input logic rd, input logic [5:0] len, input logic [23:0] a);
      logic [31:0] hdr;
      logic [7:0] rx;
      hdr = {rd, 1'b0, len, a};
      hdr_ok_q = 1'b1;
      wait_ok_q = 1'b1;
      waits_q = 0;
      #3 cs_n_o = 1'b0;
      #100;
      for (int b = 3; b >= 0; b--)
      begin
         shift(hdr[8*b+:8], rx);
         hdr_ok_q &= rx === 8'h00;
      end
      // Polling is bounded so that a target that never acknowledges cannot hang the host.
      shift(8'h00, rx);
      while (rx[0] !== 1'b1 && waits_q < 16)
      begin
         wait_ok_q &= rx === 8'h00;
         waits_q++;
         shift(8'h00, rx);
      end
      ack_q = rx;
      for (int i = 0; i <= int'(len); i++)
      begin
         shift(rd ? 8'h00 : buf_q[i], rx);
         if (rd)
            buf_q[i] = rx;
      end
      #100 cs_n_o = 1'b1;
      mosi_o = ~mosi_o;
      #300;
   endtask

   // A frame cut short after a few whole bytes; the target must fall back to idle.
   task automatic cut(input int bytes);
      logic [7:0] rx;
      #3 cs_n_o = 1'b0;
      #100;
      for (int b = 0; b < bytes; b++)
         shift(8'hff, rx);
      #100 cs_n_o = 1'b1;
      #300;
   endtask
endmodule
`default_nettype wire

/* File: verif/tb_spi_register_access_flow_control.sv */
// Self-checking bench for the serial register target, with a shadow register model.
// Assumes spi_host_model drives the serial pins; the bench drives the core-side inputs.
`timescale 1ns/1ps
`default_nettype none
module tb_spi_register_access_flow_control;
   import spi_flow_pkg::*;
   localparam logic [7:0] WWAIT = 8'h03;
   localparam logic [31:0] CAP = 32'h5a3c_0f96;
   logic core_clk_i;
   logic rstn_i;
   logic sclk;
   logic cs_n;
   logic mosi;
   logic miso;
   logic miso_oe;
   logic miso_pin;
   logic sfv;
   logic pend;
   logic [7:0] irq_ev;
   logic done;
   int error_cnt;
   int compares;
   int frames;
   int done_cnt;
   logic [6:0] own_m [5];
   logic [7:0] cfg_m [5][4];
   logic [7:0] vec_m [5];
   logic [7:0] evt_m;

   spi_register_access_flow_control #(.WRITE_WAIT_BYTES(WWAIT), .CAPABILITY(CAP)) u_dut
   (
      .core_clk_i(core_clk_i),
      .rstn_i(rstn_i),
      .spi_clk_i(sclk),
      .spi_cs_n_i(cs_n),
      .spi_mosi_i(mosi),
      .spi_miso_o(miso),
      .spi_miso_oe_o(miso_oe),
      .status_fields_valid_i(sfv),
      .read_data_pending_i(pend),
      .irq_event_i(irq_ev),
      .xfer_done_o(done)
   );

   spi_host_model u_host
   (
      .sclk_o(sclk),
      .cs_n_o(cs_n),
      .mosi_o(mosi),
      .miso_i(miso_pin)
   );

   // An undriven output line floats away from the last driven level, so a late enable shows up as a wrong bit.
   assign miso_pin = miso_oe ? miso : ~miso;

   initial
   begin
      core_clk_i = 1'b0;
      forever #5 core_clk_i = ~core_clk_i;
   end

   always @(posedge core_clk_i)
      if (done === 1'b1)
         done_cnt++;

   task automatic summarize();
      if (error_cnt == 0 && compares > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   function automatic logic mapped(input logic [23:0] a);
      return a[23:16] == BASE_HI && a[15:12] < NUM_LOC && a[11:5] == 7'h00;
   endfunction

   function automatic logic [7:0] exp_byte(input logic [23:0] a);
      int l;
      logic [4:0] o;
      l = int'(a[15:12]);
      o = a[4:0];
      if (!mapped(a)) return UNMAPPED_BYTE;
      if (o == OFF_OWNERSHIP) return {1'b1, own_m[l]};
      if (o >= OFF_INT_CONFIG && o < OFF_IRQ_VECTOR) return cfg_m[l][o - OFF_INT_CONFIG];
      if (o == OFF_IRQ_VECTOR) return vec_m[l];
      if (o == OFF_INT_EVENTS) return evt_m;
      if (o >= OFF_CAPABILITY && o < OFF_STATUS) return CAP[8*(o - OFF_CAPABILITY)+:8];
      if (o == OFF_STATUS) return {sfv, 2'b00, pend, 4'h0};
      return 8'h00;
   endfunction

   // Read-only and unmapped places keep their value, so only the writable ones are modelled.
   function automatic void wr_model(input logic [23:0] a, input logic [7:0] d);
      int l;
      logic [4:0] o;
      l = int'(a[15:12]);
      o = a[4:0];
      if (!mapped(a)) return;
      if (o == OFF_OWNERSHIP) own_m[l] = d[6:0];
      if (o >= OFF_INT_CONFIG && o < OFF_IRQ_VECTOR) cfg_m[l][o - OFF_INT_CONFIG] = d;
      if (o == OFF_IRQ_VECTOR) vec_m[l] = d;
      if (o == OFF_INT_EVENTS) evt_m &= ~d;
   endfunction

   task automatic access(input logic rd, input logic [5:0] len, input logic [23:0] a);
      logic [7:0] e [64];
      for (int i = 0; i <= int'(len); i++)
      begin
         if (!rd)
         begin
            u_host.buf_q[i] = 8'($urandom);
            wr_model(a + 24'(i), u_host.buf_q[i]);
         end
         e[i] = exp_byte(a + 24'(i));
      end
      u_host.frame(rd, len, a);
      frames++;
      chk8({7'h00, u_host.hdr_ok_q}, 8'h01);
      chk8({7'h00, u_host.wait_ok_q}, 8'h01);
      chk8(8'(u_host.waits_q), rd ? READ_WAIT_BYTES : WWAIT);
      chk8(u_host.ack_q, ACK_BYTE);
      chk8(8'(done_cnt), 8'(frames));
      chk8({7'h00, miso_oe}, 8'h00);
      if (rd)
         for (int i = 0; i <= int'(len); i++)
            chk8(u_host.buf_q[i], e[i]);
   endtask

   initial
   begin
      logic [7:0] v;
      rstn_i = 1'b0;
      sfv = 1'b0;
      pend = 1'b0;
      irq_ev = 8'h00;
      error_cnt = 0;
      compares = 0;
      frames = 0;
      done_cnt = 0;
      evt_m = 8'h00;
      void'($urandom(32'h976c));
      repeat (3) @(posedge core_clk_i);
      chk8({miso_oe, done, 6'h00}, 8'h00);
      rstn_i <= 1'b1;
      repeat (6) @(posedge core_clk_i);
      for (int l = 0; l < 5; l++)
         access(1'b0, 6'h0c, {BASE_HI, 4'(l), 12'h000});
      access(1'b1, 6'h3f, REG_BASE);
      access(1'b0, 6'h03, {BASE_HI, 4'h4, 12'h014});
      access(1'b1, 6'h03, {BASE_HI, 4'h4, 12'h014});
      access(1'b1, 6'h01, 24'h000000);
      access(1'b1, 6'h00, {BASE_HI, 4'h5, 12'h000});
      // Events and status are read back by hand, since random addresses reach them only now and then.
      @(posedge core_clk_i);
      irq_ev <= 8'ha5;
      sfv <= 1'b1;
      pend <= 1'b1;
      @(posedge core_clk_i);
      irq_ev <= 8'h00;
      evt_m |= 8'ha5;
      access(1'b1, 6'h08, {BASE_HI, 4'h2, 12'h010});
      access(1'b0, 6'h00, {BASE_HI, 4'h3, 12'h010});
      access(1'b1, 6'h10, {BASE_HI, 4'h1, 12'h000});
      // A frame cut after its acknowledge must leave no transfer behind.
      u_host.cut(6);
      chk8({7'h00, miso_oe}, 8'h00);
      chk8(8'(done_cnt), 8'(frames));
      repeat (30)
      begin
         v = 8'($urandom) & 8'($urandom);
         @(posedge core_clk_i);
         irq_ev <= v;
         sfv <= 1'($urandom);
         pend <= 1'($urandom);
         @(posedge core_clk_i);
         irq_ev <= 8'h00;
         evt_m |= v;
         access(1'($urandom), 6'($urandom_range(7)), {BASE_HI, 4'($urandom_range(5)), 6'h00, 6'($urandom_range(40))});
      end
      summarize();
   end

   initial
   begin
      #1_000_000;
      error_cnt++;
      summarize();
   end
endmodule
`default_nettype wire
